// >>> logic/agc_ctrl.sv
// gain selection and conversion sequencing for a delta-sigma converter
`timescale 1ns/100ps
//
// Contract
// - five registers, six commands via serial link
// - single-shot: one conversion, store, then idle
// - continuous: next conversion starts at completion
// - result updates whole, holds latest conversion
// - three-bit code selects eight gains
// - gains 1-4 capacitor only; higher split amplifier
// - bypass bit honoured only at gains 1-4
// - ground-referenced inputs force amplifier bypass
// - forced bypass clamps gain to four
// - modulator clock is oscillator divided by four
// - oscillator 1.024 or 2.048 MHz by mode
// - first conversion after 28.5 or 105 periods
// - done falls at end of each conversion
module agc_ctrl
    import agc_pkg::*;
#(
    parameter int CONV_PERIODS = CONV_PERIODS_DEF // conversion length in osc periods
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // decoded command strobes and configuration from the serial front end
    input wire logic begin_conversion_cmd,
    input wire logic powerdown_cmd,
    input wire logic continuous_mode,
    input wire logic turbo_mode,
    input wire logic [GAIN_W-1:0] gain_select,
    input wire logic amp_bypass_bit,
    input wire logic [MUX_W-1:0] input_select,
    // filter output, valid at the end of a conversion
    input wire logic [DATA_W-1:0] filter_data,
    // conversion status and data
    output logic conversion_done_n,
    output logic [DATA_W-1:0] result,
    output logic converting,
    output logic low_power,
    // analog front-end control
    output logic modulator_clock,
    output logic [5:0] amp_gain,
    output logic [2:0] sc_gain,
    output logic [7:0] eff_gain,
    output logic amp_enable
);
    localparam logic [CNT_W-1:0] CONV_HALF = CNT_W'(2 * CONV_PERIODS);

    agc_gain_if gi ();

    agc_gain_map u_map (
        .g (gi.map)
    );

    // ----------------------------------------------------------------
    // oscillator: fractional phase accumulator giving half-period ticks
    // ----------------------------------------------------------------
    logic [ACC_W-1:0] acc;         // phase accumulator
    logic [ACC_W-1:0] next_acc;
    logic half_tick;               // one clk per oscillator half period
    logic next_half_tick;
    logic [1:0] mod_cnt;           // half ticks within a modulator half period
    logic [1:0] next_mod_cnt;
    logic next_modulator_clock;

    // step follows the mode; wraps at the system rate in kHz
    always_comb
    begin
        logic [ACC_W:0] sum;
        sum = {1'b0, acc} + {1'b0, (turbo_mode ? STEP_TURBO : STEP_NORMAL)};
        next_half_tick = (sum >= {1'b0, ACC_MOD});
        next_acc = next_half_tick ? ACC_W'(sum - {1'b0, ACC_MOD}) : sum[ACC_W-1:0];
        next_mod_cnt = half_tick ? mod_cnt + 2'h1 : mod_cnt;
        // toggle every four half periods: one quarter of the oscillator
        next_modulator_clock = modulator_clock;
        if (half_tick && mod_cnt == 2'(MOD_DIV_HALF - 1))
        begin
            next_modulator_clock = !modulator_clock;
        end
    end

    // oscillator registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc <= '0;
            half_tick <= 1'b0;
            mod_cnt <= 2'h0;
            modulator_clock <= 1'b0;
        end
        else
        begin
            acc <= next_acc;
            half_tick <= next_half_tick;
            mod_cnt <= next_mod_cnt;
            modulator_clock <= next_modulator_clock;
        end
    end

    // ----------------------------------------------------------------
    // conversion sequencer
    // ----------------------------------------------------------------
    agc_state_t state;             // sequencer state
    agc_state_t next_state;
    logic [CNT_W-1:0] cnt;         // half ticks spent in the current state
    logic [CNT_W-1:0] next_cnt;
    logic [CNT_W-1:0] dly_target;  // start delay for the mode in force
    logic [CNT_W-1:0] next_dly_target;
    logic conv_end;                // last half tick of a conversion
    logic latch_cfg;               // settings captured for the conversion
    logic [GAIN_W-1:0] cfg_gain;   // latched gain code
    logic [GAIN_W-1:0] next_cfg_gain;
    logic cfg_bypass;              // latched bypass bit
    logic next_cfg_bypass;
    logic [MUX_W-1:0] cfg_mux;     // latched input code
    logic [MUX_W-1:0] next_cfg_mux;
    logic [DATA_W-1:0] next_result;
    logic [1:0] done_cnt;          // half ticks left with done low
    logic [1:0] next_done_cnt;
    logic next_done_n;

    // state and counters; commands arrive already decoded from the link
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_dly_target = dly_target;
        latch_cfg = 1'b0;
        conv_end = (state == ST_CONV) && half_tick && (cnt == CONV_HALF - 1'b1);
        case (state)
            ST_IDLE:
                next_cnt = '0;
            ST_DELAY:
            begin
                if (half_tick)
                begin
                    next_cnt = cnt + 1'b1;
                    if (cnt == dly_target - 1'b1)
                    begin
                        next_state = ST_CONV;
                        next_cnt = '0;
                        latch_cfg = 1'b1;
                    end
                end
            end
            ST_CONV:
            begin
                if (half_tick)
                begin
                    next_cnt = cnt + 1'b1;
                end
                if (conv_end)
                begin
                    next_cnt = '0;
                    if (continuous_mode)
                    begin
                        latch_cfg = 1'b1;
                    end
                    else
                    begin
                        next_state = ST_IDLE;
                    end
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
        // start restarts any conversion; power-down wins over start
        if (begin_conversion_cmd)
        begin
            next_state = ST_DELAY;
            next_cnt = '0;
            next_dly_target = turbo_mode ? START_TURBO_HALF : START_NORMAL_HALF;
        end
        if (powerdown_cmd)
        begin
            next_state = ST_IDLE;
            next_cnt = '0;
        end
        next_cfg_gain = latch_cfg ? gain_select : cfg_gain;
        next_cfg_bypass = latch_cfg ? amp_bypass_bit : cfg_bypass;
        next_cfg_mux = latch_cfg ? input_select : cfg_mux;
        // whole word replaced in one edge, never piecewise
        next_result = conv_end ? filter_data : result;
        next_done_cnt = done_cnt;
        next_done_n = conversion_done_n;
        if (conv_end)
        begin
            next_done_n = 1'b0;
            next_done_cnt = 2'(DONE_LOW_HALF);
        end
        else if (half_tick && done_cnt != 2'h0)
        begin
            next_done_cnt = done_cnt - 2'h1;
            next_done_n = (done_cnt == 2'h1);
        end
    end

    // sequencer registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state <= ST_IDLE;
            cnt <= '0;
            dly_target <= START_NORMAL_HALF;
            cfg_gain <= '0;
            cfg_bypass <= 1'b0;
            cfg_mux <= '0;
            result <= RESULT_RST;
            done_cnt <= 2'h0;
            conversion_done_n <= 1'b1;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            dly_target <= next_dly_target;
            cfg_gain <= next_cfg_gain;
            cfg_bypass <= next_cfg_bypass;
            cfg_mux <= next_cfg_mux;
            result <= next_result;
            done_cnt <= next_done_cnt;
            conversion_done_n <= next_done_n;
        end
    end

    assign gi.gain_select = cfg_gain;
    assign gi.amp_bypass_bit = cfg_bypass;
    assign gi.input_select = cfg_mux;

    // ----------------------------------------------------------------
    // registered outputs
    // ----------------------------------------------------------------
    // front-end controls follow the latched settings; amp_enable is also held low while idle
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            amp_gain <= 6'h01;
            sc_gain <= 3'h1;
            eff_gain <= 8'h01;
            amp_enable <= 1'b0;
            converting <= 1'b0;
            low_power <= 1'b1;
        end
        else
        begin
            amp_gain <= gi.amp_gain;
            sc_gain <= gi.sc_gain;
            eff_gain <= gi.eff_gain;
            amp_enable <= gi.amp_enable && (next_state != ST_IDLE);
            converting <= (next_state == ST_CONV);
            low_power <= (next_state == ST_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_conv_done;
        conv_end && !begin_conversion_cmd && !powerdown_cmd;
    endsequence

    property p_single_idle;
        s_conv_done ##0 !continuous_mode |=> state == ST_IDLE && low_power;
    endproperty
    a_single_idle: assert property (p_single_idle) else $error("single-shot did not idle");

    property p_cont_next;
        s_conv_done ##0 continuous_mode |=> state == ST_CONV && cnt == '0;
    endproperty
    a_cont_next: assert property (p_cont_next) else $error("continuous did not restart");

    property p_result_whole;
        s_conv_done |=> result == $past(filter_data) && !conversion_done_n;
    endproperty
    a_result_whole: assert property (p_result_whole) else $error("result not captured");

    property p_result_hold;
        !conv_end |=> $stable(result);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed mid-conversion");

    property p_split;
        amp_gain * sc_gain == eff_gain && sc_gain <= 3'h4 && amp_gain <= 6'h20;
    endproperty
    a_split: assert property (p_split) else $error("gain split wrong");

    property p_forced;
        gi.forced_bypass |-> !gi.amp_enable && gi.eff_gain <= 8'h04 && gi.amp_gain == 6'h01;
    endproperty
    a_forced: assert property (p_forced) else $error("forced bypass not applied");

    property p_bypass_gate;
        cfg_bypass && cfg_gain > GAIN_SC_MAX && !gi.forced_bypass |-> gi.amp_enable;
    endproperty
    a_bypass_gate: assert property (p_bypass_gate) else $error("bypass honoured at high gain");

    property p_start_delay;
        state == ST_DELAY && half_tick && cnt == dly_target - 1'b1
            && !begin_conversion_cmd && !powerdown_cmd |=> state == ST_CONV && converting;
    endproperty
    a_start_delay: assert property (p_start_delay) else $error("start delay wrong");

    property p_no_early;
        state == ST_DELAY && cnt < dly_target - 1'b1 && !half_tick |=> state != ST_CONV;
    endproperty
    a_no_early: assert property (p_no_early) else $error("conversion started early");

    property p_mod_clk;
        !(half_tick && mod_cnt == 2'h3) |=> $stable(modulator_clock);
    endproperty
    a_mod_clk: assert property (p_mod_clk) else $error("modulator clock off rate");

    property p_cfg_stable;
        state == ST_CONV && !conv_end && !begin_conversion_cmd |=> $stable(cfg_gain)
            && $stable(cfg_mux) && $stable(cfg_bypass);
    endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("settings changed mid-conversion");
endmodule : agc_ctrl

// >>> logic/agc_gain_if.sv
// carrier of latched gain settings and the resulting gain split
`timescale 1ns/100ps
interface agc_gain_if;
    import agc_pkg::*;
    logic [GAIN_W-1:0] gain_select;     // latched gain code
    logic amp_bypass_bit;               // latched bypass request
    logic [MUX_W-1:0] input_select;     // latched input pair code
    logic [5:0] amp_gain;               // amplifier gain value
    logic [2:0] sc_gain;                // switched-capacitor gain value
    logic [7:0] eff_gain;               // overall gain value
    logic amp_enable;                   // amplifier powered and in path
    logic forced_bypass;                // ground-referenced input selected
    modport cfg (output gain_select, amp_bypass_bit, input_select,
                 input amp_gain, sc_gain, eff_gain, amp_enable, forced_bypass);
    modport map (input gain_select, amp_bypass_bit, input_select,
                 output amp_gain, sc_gain, eff_gain, amp_enable, forced_bypass);
endinterface : agc_gain_if

// >>> logic/agc_gain_map.sv
// gain code decoder: splits the gain between amplifier and capacitor stage
`timescale 1ns/100ps
module agc_gain_map
    import agc_pkg::*;
(
    // settings in, gain split out
    agc_gain_if.map g
);
    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [GAIN_W-1:0] eff_code; // gain code after any clamp
    logic [GAIN_W-1:0] sc_code;  // capacitor stage log2 gain
    logic [GAIN_W-1:0] amp_code; // amplifier log2 gain

    // ground-referenced pairs force bypass and clamp to gain 4
    always_comb
    begin
        g.forced_bypass = (g.input_select >= MUX_GND_LO) && (g.input_select <= MUX_GND_HI);
        eff_code = (g.forced_bypass && g.gain_select > GAIN_SC_MAX) ? GAIN_SC_MAX
                   : g.gain_select;
        // bypass request only counts at gains 1, 2 and 4
        g.amp_enable = !(g.forced_bypass
                         || (g.amp_bypass_bit && g.gain_select <= GAIN_SC_MAX));
        sc_code = (eff_code > GAIN_SC_MAX) ? GAIN_SC_MAX : eff_code;
        amp_code = eff_code - sc_code;
        g.sc_gain = 3'h1 << sc_code;
        g.amp_gain = 6'h01 << amp_code;
        g.eff_gain = 8'h01 << eff_code;
    end
endmodule : agc_gain_map

// >>> logic/agc_pkg.sv
// constants and types shared by the gain and conversion control block
package agc_pkg;
    // ----------------------------------------------------------------
    // clock and oscillator rates, in kHz
    // ----------------------------------------------------------------
    localparam int CLK_KHZ = 50000;          // system clock, 20 ns period
    localparam int OSC_NORMAL_KHZ = 1024;    // oscillator in normal mode
    localparam int OSC_TURBO_KHZ = 2048;     // oscillator in turbo mode
    localparam int ACC_W = 16;               // phase accumulator width
    // half oscillator periods are the time grain, so steps are doubled
    localparam logic [ACC_W-1:0] STEP_NORMAL = ACC_W'(2 * OSC_NORMAL_KHZ);
    localparam logic [ACC_W-1:0] STEP_TURBO = ACC_W'(2 * OSC_TURBO_KHZ);
    localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(CLK_KHZ);
    // ----------------------------------------------------------------
    // start delay, in tenths of oscillator periods, and in half periods
    // ----------------------------------------------------------------
    localparam int START_NORMAL_TENTHS = 285;
    localparam int START_TURBO_TENTHS = 1050;
    localparam int CNT_W = 18;               // delay and conversion counter width
    localparam logic [CNT_W-1:0] START_NORMAL_HALF = CNT_W'(START_NORMAL_TENTHS * 2 / 10);
    localparam logic [CNT_W-1:0] START_TURBO_HALF = CNT_W'(START_TURBO_TENTHS * 2 / 10);
    localparam int CONV_PERIODS_DEF = 1036;  // default conversion length, osc periods
    localparam int MOD_DIV_HALF = 4;         // modulator half period, in osc half periods
    localparam int DONE_LOW_HALF = 2;        // done stays low one osc period
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int GAIN_W = 3;               // gain_select width
    localparam int MUX_W = 4;                // input_select width
    localparam int DATA_W = 24;              // conversion result width
    localparam logic [MUX_W-1:0] MUX_GND_LO = 4'h8;  // first ground-referenced code
    localparam logic [MUX_W-1:0] MUX_GND_HI = 4'hb;  // last ground-referenced code
    localparam logic [GAIN_W-1:0] GAIN_SC_MAX = 3'h2; // code of gain 4
    localparam logic [DATA_W-1:0] RESULT_RST = 24'h000000;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} agc_state_t;
endpackage : agc_pkg

// >>> tb/agc_ctrl_bench.sv
// self-checking bench of the gain and conversion control block
`timescale 1ns/100ps
module agc_ctrl_bench;
    import agc_pkg::*;
    // ----------------------------------------------------------------
    // stimulus, observed outputs and bookkeeping
    // ----------------------------------------------------------------
    localparam int CONV_P = 8; // short conversion keeps the run brief
    localparam logic [DATA_W-1:0] SEED = 24'h5a3c01; // first filter word
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic begin_conversion_cmd = 1'b0;
    logic powerdown_cmd = 1'b0;
    logic continuous_mode = 1'b0;
    logic turbo_mode = 1'b0;
    logic [GAIN_W-1:0] gain_select = 3'h0;
    logic amp_bypass_bit = 1'b0;
    logic [MUX_W-1:0] input_select = 4'h0;
    logic [DATA_W-1:0] filter_data;
    logic [DATA_W-1:0] result;
    logic conversion_done_n, converting, low_power, modulator_clock, amp_enable;
    logic [5:0] amp_gain;
    logic [2:0] sc_gain;
    logic [7:0] eff_gain;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0; // timeout counter
    int conv_n = 0; // conversions completed so far
    int n; // measured cycle count
    // settings table: gain code, bypass bit, input pair code
    logic [7:0] cases [14] = '{8'h00, 8'h10, 8'h30, 8'h50, 8'h60, 8'h90, 8'ha0,
        8'hc0, 8'hf0, 8'he8, 8'h5b, 8'h09, 8'hba, 8'h77};
    // ----------------------------------------------------------------
    // block under test and filter model
    // ----------------------------------------------------------------
    agc_ctrl #(.CONV_PERIODS(CONV_P)) i_agc_ctrl (.clk(clk), .reset(reset),
        .begin_conversion_cmd(begin_conversion_cmd), .powerdown_cmd(powerdown_cmd),
        .continuous_mode(continuous_mode), .turbo_mode(turbo_mode),
        .gain_select(gain_select), .amp_bypass_bit(amp_bypass_bit),
        .input_select(input_select), .filter_data(filter_data),
        .conversion_done_n(conversion_done_n), .result(result), .converting(converting),
        .low_power(low_power), .modulator_clock(modulator_clock), .amp_gain(amp_gain),
        .sc_gain(sc_gain), .eff_gain(eff_gain), .amp_enable(amp_enable));
    agc_filter_model #(.SEED(SEED)) i_agc_filter_model (.clk(clk), .reset(reset),
        .conversion_done_n(conversion_done_n), .filter_data(filter_data));
    // 50 MHz clock
    always #10 clk = ~clk;
    // hang guard: well above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            fail_count++;
            conclude();
        end
    end
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    // compare one value, report a mismatch
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // verdict and end of run
    task automatic conclude();
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    // apply one settings entry at a rising edge
    task automatic set_cfg(input logic [7:0] k);
        @(posedge clk);
        gain_select <= k[7:5];
        amp_bypass_bit <= k[4];
        input_select <= k[3:0];
    endtask : set_cfg
    // one-clock start command, taken at the second edge
    task automatic pulse_start();
        @(posedge clk) begin_conversion_cmd <= 1'b1;
        @(posedge clk) begin_conversion_cmd <= 1'b0;
    endtask : pulse_start
    // cycles until a conversion is running
    task automatic wait_conv(output int c);
        c = 0;
        do @(negedge clk) c++; while (converting !== 1'b1 && c < 4000);
    endtask : wait_conv
    // cycles until the next falling done, counting the low part left over
    task automatic wait_done(output int c);
        c = 0;
        while (conversion_done_n === 1'b0 && c < 4000)
            @(negedge clk) c++;
        do @(negedge clk) c++; while (conversion_done_n !== 1'b0 && c < 4000);
        conv_n++;
    endtask : wait_done
    // length of one full half period of the modulator clock
    task automatic mod_half(output int c);
        logic v;
        @(negedge clk) v = modulator_clock;
        c = 0;
        while (modulator_clock === v && c < 400)
            @(negedge clk) c++;
        v = modulator_clock;
        c = 0;
        while (modulator_clock === v && c < 400)
            @(negedge clk) c++;
    endtask : mod_half
    // expected gain split for one settings entry
    task automatic check_gains(input logic [7:0] k, input logic on);
        logic [7:0] eff;
        logic [2:0] sc;
        logic forced;
        forced = k[3:0] >= MUX_GND_LO && k[3:0] <= MUX_GND_HI;
        eff = 8'h01 << k[7:5];
        // forced bypass clamps gains above four
        if (forced && k[7:5] > GAIN_SC_MAX)
            eff = 8'h04;
        sc = (eff > 8'h04) ? 3'h4 : eff[2:0];
        check(32'(amp_gain), 32'(eff / 8'(sc)));
        check(32'(sc_gain), 32'(sc));
        check(32'(eff_gain), 32'(eff));
        check(32'(amp_enable), 32'(on && !forced && !(k[4] && k[7:5] <= 3'h2)));
    endtask : check_gains
    // ----------------------------------------------------------------
    // test sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        // values straight after reset
        check(32'(conversion_done_n), 32'h1);
        check(32'(result), 32'h0);
        check(32'(converting), 32'h0);
        check(32'(low_power), 32'h1);
        check_gains(8'h00, 1'b0);
        // single shot, normal mode, settings changed mid conversion
        set_cfg(8'ha0);
        pulse_start();
        repeat (2) @(negedge clk);
        check(32'(low_power), 32'h0);
        wait_conv(n);
        check(32'(n >= 1360 && n <= 1425), 32'h1);
        set_cfg(8'h00);
        repeat (3) @(negedge clk);
        check_gains(8'ha0, 1'b1);
        mod_half(n);
        check(32'(n >= 95 && n <= 100), 32'h1);
        wait_done(n);
        check(32'(result), 32'(SEED));
        repeat (3) @(negedge clk);
        check(32'(converting), 32'h0);
        check(32'(low_power), 32'h1);
        check(32'(amp_enable), 32'h0);
        repeat (600) @(negedge clk);
        check(32'(conversion_done_n), 32'h1);
        // continuous mode walking the settings table
        @(posedge clk) continuous_mode <= 1'b1;
        set_cfg(cases[0]);
        pulse_start();
        wait_conv(n);
        repeat (3) @(negedge clk);
        check_gains(cases[0], 1'b1);
        for (int i = 1; i < 14; i++)
        begin
            set_cfg(cases[i]);
            wait_done(n);
            // spacing of done edges is the conversion length
            if (i > 1)
                check(32'(n >= 385 && n <= 397), 32'h1);
            check(32'(result), 32'(SEED + DATA_W'(conv_n - 1)));
            repeat (3) @(negedge clk);
            check_gains(cases[i], 1'b1);
        end
        // power-down aborts the running conversion
        @(posedge clk) powerdown_cmd <= 1'b1;
        @(posedge clk) powerdown_cmd <= 1'b0;
        repeat (600) @(negedge clk);
        check(32'(converting), 32'h0);
        check(32'(low_power), 32'h1);
        check(32'(conversion_done_n), 32'h1);
        // single shot in turbo mode
        @(posedge clk);
        continuous_mode <= 1'b0;
        turbo_mode <= 1'b1;
        pulse_start();
        wait_conv(n);
        check(32'(n >= 2540 && n <= 2590), 32'h1);
        mod_half(n);
        check(32'(n >= 47 && n <= 51), 32'h1);
        wait_done(n);
        check(32'(result), 32'(SEED + DATA_W'(conv_n - 1)));
        conclude();
    end
endmodule : agc_ctrl_bench

// >>> tb/agc_filter_model.sv
// filter model: hands the block a fresh conversion word after each done flag
`timescale 1ns/100ps
module agc_filter_model
    import agc_pkg::*;
#(
    parameter logic [DATA_W-1:0] SEED = 24'h5a3c01 // first word handed out
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // done flag in, conversion word out
    input wire logic conversion_done_n,
    output logic [DATA_W-1:0] filter_data
);
    logic done_q; // done flag one clock ago
    // ----------------------------------------------------------------
    // word steps after each falling done, so it is steady at conversion end
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            done_q <= 1'b1;
            filter_data <= SEED;
        end
        else
        begin
            done_q <= conversion_done_n;
            // a new word only once the previous one was taken
            if (done_q && !conversion_done_n)
            begin
                filter_data <= filter_data + 24'h000001;
            end
        end
    end
endmodule : agc_filter_model
